// File: hw/ecc_pkg.sv
package ecc_pkg;
  // Register map of the external debug interface
  localparam logic [11:0] ECC_CTRL_OFFSET = 12'h098;
  localparam int ECC_DATA_W = 32;
  // Entry-catch field positions
  localparam int ECC_S_EL0_ENTRY_BIT = 0;
  localparam int ECC_S_EL1_ENTRY_BIT = 1;
  localparam int ECC_S_EL2_ENTRY_BIT = 2;
  localparam int ECC_EL3_ENTRY_BIT = 3;
  localparam int ECC_NS_EL0_ENTRY_BIT = 4;
  localparam int ECC_NS_EL1_ENTRY_BIT = 5;
  localparam int ECC_NS_EL2_ENTRY_BIT = 6;
  // Return-catch field positions
  localparam int ECC_S_EL1_RETURN_BIT = 9;
  localparam int ECC_S_EL2_RETURN_BIT = 10;
  localparam int ECC_EL3_RETURN_BIT = 11;
  localparam int ECC_NS_EL1_RETURN_BIT = 13;
  localparam int ECC_NS_EL2_RETURN_BIT = 14;
  localparam logic [31:0] ECC_CTRL_RESET = 32'h0000_0000;
  // Access verdict of the lock gating
  typedef enum logic [1:0] {ECC_ACC_RW, ECC_ACC_RO, ECC_ACC_ERR} ecc_access_t;
endpackage

// File: hw/ecc_level_catch.sv
`timescale 1ns/100ps
// Per-level catch selector: entry and return bits, fine or coarse mode
module ecc_level_catch
  import ecc_pkg::*;
#(
  parameter bit FINE = 1'b1,
  parameter bit RESET_ENTRY_CATCH = 1'b1
) (
  // Control bits
  input wire logic entry_bit,
  input wire logic return_bit,
  // Events at this level
  input wire logic exc_entry,
  input wire logic reset_entry,
  input wire logic exc_return,
  // Catch event
  output logic catch_hit
);
  logic en_entry;
  logic en_return;

  always_comb begin
    if (FINE) begin
      en_entry = entry_bit;
      en_return = entry_bit ^ return_bit;
    end else begin
      en_entry = entry_bit;
      en_return = entry_bit;
    end
    catch_hit = (en_entry & exc_entry) | (en_entry & reset_entry & RESET_ENTRY_CATCH) | (en_return & exc_return);
  end
endmodule // ecc_level_catch

// File: hw/ecc_catch_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// RULE1 - Coarse NS EL2 bit enables its catch; the code adds an NS EL2 return bit at 14 in fine builds
// RULE2 - NS EL1 entry/return pair selects four cases
// RULE3 - EL3 entry/return pair selects four cases
// RULE4 - Secure EL2 pair needs both features
// RULE5 - Secure EL1 pair selects four cases
// RULE6 - Without fine catch NS EL1 coarse
// RULE7 - Without fine catch EL3 bit coarse
// RULE8 - Without fine catch Secure EL1 coarse
// RULE9 - Reset-entry catch is build-time choice
// RULE10 - Cold reset clears all catch bits
// RULE11 - EL0 entry bits read zero
// RULE12 - Register decoded at offset 0x098
// RULE13 - Software lock makes register read-only
// RULE14 - All locks clear: read and write
// RULE15 - Otherwise every access errors
// RULE16 - Return bits at 9, 10, 11, 13; the code also has an NS EL2 return bit at 14
// RULE17 - Unimplemented catch bits read zero
module ecc_catch_ctrl
  import ecc_pkg::*;
#(
  parameter bit FINE_GRAINED_CATCH_FEATURE = 1'b1,
  parameter bit SECURE_EL2_FEATURE = 1'b1,
  parameter bit HAS_EL3 = 1'b1,
  parameter bit HAS_NS_EL2 = 1'b1,
  parameter bit HAS_S_EL1 = 1'b1,
  parameter bit HAS_NS_EL1 = 1'b1,
  parameter bit RESET_ENTRY_CATCH = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // External debug access port
  input wire logic req,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic err,
  output logic [31:0] rdata,
  // Power and lock state
  input wire logic core_powered_state,
  input wire logic double_lock_state,
  input wire logic os_lock_state,
  input wire logic software_lock_state,
  // Exception events per level: bit index as entry-catch field
  input wire logic [6:0] exc_entry,
  input wire logic [6:0] reset_entry,
  input wire logic [6:0] exc_return,
  // Catch events
  output logic [6:0] catch_event
);
  // Secure EL2 cannot be built without Secure EL1
  if (SECURE_EL2_FEATURE && !HAS_S_EL1) begin : g_bad_cfg
    $error("Secure EL2 needs Secure EL1");
  end

  // Writable mask of implemented fields
  function automatic logic [31:0] impl_mask();
    logic [31:0] m;
    logic f;
    m = 32'h0000_0000;
    f = FINE_GRAINED_CATCH_FEATURE;
    m[ECC_NS_EL2_ENTRY_BIT] = HAS_NS_EL2; // [RULE1]
    m[ECC_NS_EL1_ENTRY_BIT] = HAS_NS_EL1; // [RULE2] [RULE6]
    m[ECC_EL3_ENTRY_BIT] = HAS_EL3; // [RULE3] [RULE7]
    m[ECC_S_EL2_ENTRY_BIT] = f & SECURE_EL2_FEATURE; // [RULE4]
    m[ECC_S_EL1_ENTRY_BIT] = HAS_S_EL1; // [RULE5] [RULE8]
    m[ECC_NS_EL2_RETURN_BIT] = f & HAS_NS_EL2;
    m[ECC_NS_EL1_RETURN_BIT] = f & HAS_NS_EL1; // [RULE16]
    m[ECC_EL3_RETURN_BIT] = f & HAS_EL3; // [RULE16]
    m[ECC_S_EL2_RETURN_BIT] = f & SECURE_EL2_FEATURE; // [RULE16]
    m[ECC_S_EL1_RETURN_BIT] = f & HAS_S_EL1; // [RULE16]
    m[ECC_NS_EL0_ENTRY_BIT] = 1'b0; // [RULE11]
    m[ECC_S_EL0_ENTRY_BIT] = 1'b0; // [RULE11]
    return m; // [RULE17]
  endfunction

  localparam logic [31:0] IMPL_MASK = impl_mask();

  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic next_ack;
  logic next_err;
  logic [31:0] next_rdata;
  logic hit;
  ecc_access_t access;

  always_comb begin
    hit = req && (addr == ECC_CTRL_OFFSET); // [RULE12]
    if (core_powered_state && !double_lock_state && !os_lock_state) begin
      access = software_lock_state ? ECC_ACC_RO : ECC_ACC_RW; // [RULE13] [RULE14]
    end else begin
      access = ECC_ACC_ERR; // [RULE15]
    end
    next_ctrl = ctrl;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (req) begin
      next_ack = 1'b1;
      if (hit) begin
        case (access)
          ECC_ACC_RW: begin
            if (wr) begin
              next_ctrl = wdata & IMPL_MASK; // [RULE14] [RULE11] [RULE17]
            end else begin
              next_rdata = ctrl;
            end
          end
          ECC_ACC_RO: begin
            if (!wr) begin
              next_rdata = ctrl; // [RULE13]
            end
          end
          ECC_ACC_ERR: begin
            next_err = 1'b1; // [RULE15]
          end
          default: begin
            next_err = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl <= ECC_CTRL_RESET; // [RULE10]
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  // Return bit per level index; zero where no return field exists
  logic [6:0] ret_bits;
  always_comb begin
    ret_bits = 7'h00;
    ret_bits[ECC_NS_EL2_ENTRY_BIT] = ctrl[ECC_NS_EL2_RETURN_BIT];
    ret_bits[ECC_NS_EL1_ENTRY_BIT] = ctrl[ECC_NS_EL1_RETURN_BIT];
    ret_bits[ECC_EL3_ENTRY_BIT] = ctrl[ECC_EL3_RETURN_BIT];
    ret_bits[ECC_S_EL2_ENTRY_BIT] = ctrl[ECC_S_EL2_RETURN_BIT];
    ret_bits[ECC_S_EL1_ENTRY_BIT] = ctrl[ECC_S_EL1_RETURN_BIT];
  end

  for (genvar i = 0; i < 7; i++) begin : g_lvl
    ecc_level_catch #(
      .FINE(FINE_GRAINED_CATCH_FEATURE),
      .RESET_ENTRY_CATCH(RESET_ENTRY_CATCH) // [RULE9]
    ) u_lvl (
      .entry_bit(ctrl[i]), // [RULE1] [RULE2] [RULE3] [RULE5] [RULE6] [RULE7] [RULE8]
      .return_bit(ret_bits[i]),
      .exc_entry(exc_entry[i]),
      .reset_entry(reset_entry[i]),
      .exc_return(exc_return[i]),
      .catch_hit(catch_event[i])
    );
  end

  // Assertions
  AST_RESET_CLEARS: assert property (@(posedge clock) rst |=> ctrl == 32'h0000_0000) // [RULE10]
    else $error("catch bits not cleared by reset");
  AST_EL0_ZERO: assert property (@(posedge clock) disable iff (rst)
    ctrl[ECC_NS_EL0_ENTRY_BIT] == 1'b0 && ctrl[ECC_S_EL0_ENTRY_BIT] == 1'b0) // [RULE11]
    else $error("EL0 catch bit set");
  AST_ERR_LOCKED: assert property (@(posedge clock) disable iff (rst)
    (req && addr == ECC_CTRL_OFFSET && (!core_powered_state || double_lock_state || os_lock_state))
    |=> (ack && err)) // [RULE15]
    else $error("locked access not errored");
  AST_RO_NO_WRITE: assert property (@(posedge clock) disable iff (rst)
    (req && wr && core_powered_state && !double_lock_state && !os_lock_state && software_lock_state)
    |=> ($stable(ctrl) && !err)) // [RULE13]
    else $error("write taken under software lock");
  AST_RW_WRITE: assert property (@(posedge clock) disable iff (rst)
    (req && wr && addr == ECC_CTRL_OFFSET && core_powered_state && !double_lock_state && !os_lock_state
    && !software_lock_state) |=> (ctrl == ($past(wdata) & IMPL_MASK))) // [RULE14]
    else $error("write not stored");
  AST_RW_READ: assert property (@(posedge clock) disable iff (rst)
    (req && !wr && addr == ECC_CTRL_OFFSET && core_powered_state && !double_lock_state && !os_lock_state)
    |=> (rdata == $past(ctrl) && ack && !err)) // [RULE12]
    else $error("read data wrong");
  AST_OTHER_ADDR: assert property (@(posedge clock) disable iff (rst)
    (req && wr && addr != ECC_CTRL_OFFSET) |=> ($stable(ctrl) && rdata == 32'h0000_0000)) // [RULE12]
    else $error("other offset touched register");
  AST_UNIMPL_ZERO: assert property (@(posedge clock) disable iff (rst) (ctrl & ~IMPL_MASK) == 32'h0000_0000) // [RULE17]
    else $error("unimplemented bit set");
  AST_NS_EL1_RET_ONLY: assert property (@(posedge clock) disable iff (rst)
    (FINE_GRAINED_CATCH_FEATURE && !ctrl[ECC_NS_EL1_ENTRY_BIT] && ctrl[ECC_NS_EL1_RETURN_BIT]
    && exc_entry[ECC_NS_EL1_ENTRY_BIT] && !exc_return[ECC_NS_EL1_ENTRY_BIT] && !reset_entry[ECC_NS_EL1_ENTRY_BIT])
    |-> !catch_event[ECC_NS_EL1_ENTRY_BIT]) // [RULE2]
    else $error("entry caught in return-only mode");
  AST_EL3_NO_RETURN: assert property (@(posedge clock) disable iff (rst)
    (FINE_GRAINED_CATCH_FEATURE && ctrl[ECC_EL3_ENTRY_BIT] && ctrl[ECC_EL3_RETURN_BIT]
    && exc_return[ECC_EL3_ENTRY_BIT] && !exc_entry[ECC_EL3_ENTRY_BIT] && !reset_entry[ECC_EL3_ENTRY_BIT])
    |-> !catch_event[ECC_EL3_ENTRY_BIT]) // [RULE3]
    else $error("return caught with both EL3 bits set");
  AST_RESET_ENTRY_FIXED: assert property (@(posedge clock) disable iff (rst)
    (ctrl[ECC_S_EL1_ENTRY_BIT] && reset_entry[ECC_S_EL1_ENTRY_BIT] && !exc_entry[ECC_S_EL1_ENTRY_BIT]
    && !exc_return[ECC_S_EL1_ENTRY_BIT]) |-> (catch_event[ECC_S_EL1_ENTRY_BIT] == RESET_ENTRY_CATCH)) // [RULE9]
    else $error("reset entry catch differs from build choice");
  // Coarse build: the entry bit alone decides entry and return catch of its level
  AST_COARSE_NS_EL1: assert property (@(posedge clock) disable iff (rst)
    (!FINE_GRAINED_CATCH_FEATURE && exc_return[ECC_NS_EL1_ENTRY_BIT])
    |-> (catch_event[ECC_NS_EL1_ENTRY_BIT] == ctrl[ECC_NS_EL1_ENTRY_BIT])) // [RULE6]
    else $error("coarse NS EL1 catch wrong");
  AST_COARSE_EL3: assert property (@(posedge clock) disable iff (rst)
    (!FINE_GRAINED_CATCH_FEATURE && exc_return[ECC_EL3_ENTRY_BIT])
    |-> (catch_event[ECC_EL3_ENTRY_BIT] == ctrl[ECC_EL3_ENTRY_BIT])) // [RULE7]
    else $error("coarse EL3 catch wrong");
  AST_COARSE_S_EL1: assert property (@(posedge clock) disable iff (rst)
    (!FINE_GRAINED_CATCH_FEATURE && exc_return[ECC_S_EL1_ENTRY_BIT])
    |-> (catch_event[ECC_S_EL1_ENTRY_BIT] == ctrl[ECC_S_EL1_ENTRY_BIT])) // [RULE8]
    else $error("coarse Secure EL1 catch wrong");
  // Refused access: error answer one cycle on, no data, register untouched
  sequence s_locked_req;
    req && addr == ECC_CTRL_OFFSET && (!core_powered_state || double_lock_state || os_lock_state);
  endsequence
  sequence s_error_answer;
    ack && err && rdata == 32'h0000_0000;
  endsequence
  AST_LOCKED_ANSWER: assert property (@(posedge clock) disable iff (rst) s_locked_req |=> s_error_answer) // [RULE15]
    else $error("refused access returned data");
  AST_LOCKED_NO_WRITE: assert property (@(posedge clock) disable iff (rst) s_locked_req |=> $stable(ctrl)) // [RULE15]
    else $error("write taken while locked");
  AST_ACK_FOLLOWS_REQ: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |-> (ack == $past(req))) // [RULE12]
    else $error("answer not one cycle after request");
endmodule // ecc_catch_ctrl

// File: verif/ecc_dbg_model.sv
`timescale 1ns/100ps
// Debugger side of the access port
module ecc_dbg_model (
  // Clock
  input wire logic clock,
  // Access port
  output logic req,
  output logic wr,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [31:0] rdata
);
  initial begin
    req = 1'b0;
    wr = 1'b0;
    addr = 12'h000;
    wdata = 32'h0;
  end
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, output logic e,
    output logic [31:0] rd, output logic to);
    @(posedge clock);
    #1;
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clock);
    #1;
    req = 1'b0;
    // Released lines must not keep the last value
    wr = ~w;
    addr = ~a;
    wdata = ~d;
    // Answer stands for the cycle after the request edge; look while it stands
    to = 1'b1;
    for (int i = 0; i < 4 && to; i++) begin
      if (ack === 1'b1) begin
        e = err;
        rd = rdata;
        to = 1'b0;
      end else begin
        @(posedge clock);
        #1;
      end
    end
  endtask
endmodule // ecc_dbg_model

// File: verif/tb_exception_catch_control.sv
`timescale 1ns/100ps
module tb_exception_catch_control;
  import ecc_pkg::*;
  localparam logic [11:0] OF = ECC_CTRL_OFFSET;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic req, wr, ack, err, pwr, dbl, os, sw;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [6:0] ee, re, xr, ce, cc;
  int fails = 0;
  int comparisons = 0;
  // Stored value and catch expected on entry and on return
  logic [31:0] cv [4] = '{32'h006e, 32'h6e00, 32'h0, 32'h6e6e};
  logic [6:0] xe [4] = '{7'h6e, 7'h00, 7'h00, 7'h6e};
  logic [6:0] xx [4] = '{7'h6e, 7'h6e, 7'h00, 7'h00};
  // Coarse build: entry bit enables every event, Secure EL2 field absent
  logic [6:0] xc [4] = '{7'h6a, 7'h00, 7'h00, 7'h6a};
  initial begin
    forever #2.5 clock = ~clock;
  end
  ecc_catch_ctrl dut_u (.clock(clock), .rst(rst), .req(req), .wr(wr), .addr(addr), .wdata(wdata),
    .ack(ack), .err(err), .rdata(rdata), .core_powered_state(pwr), .double_lock_state(dbl),
    .os_lock_state(os), .software_lock_state(sw), .exc_entry(ee), .reset_entry(re),
    .exc_return(xr), .catch_event(ce));
  ecc_catch_ctrl #(.FINE_GRAINED_CATCH_FEATURE(1'b0)) dut_coarse_u (.clock(clock), .rst(rst), .req(req),
    .wr(wr), .addr(addr), .wdata(wdata), .ack(), .err(), .rdata(), .core_powered_state(pwr),
    .double_lock_state(dbl), .os_lock_state(os), .software_lock_state(sw), .exc_entry(ee),
    .reset_entry(re), .exc_return(xr), .catch_event(cc));
  ecc_dbg_model m_u (.clock(clock), .req(req), .wr(wr), .addr(addr), .wdata(wdata), .ack(ack),
    .err(err), .rdata(rdata));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One access, error flag compared
  task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d, input logic xf);
    logic e;
    logic to;
    m_u.acc(w, a, d, e, rd, to);
    if (to !== 1'b0) begin
      fails++;
      give_verdict();
    end else begin
      chk({31'h0, e}, {31'h0, xf});
    end
  endtask
  // One kind of event on every level, catch compared on both builds
  task automatic ev_chk(input int k, input logic [6:0] xf, input logic [6:0] xcs);
    @(posedge clock);
    #1;
    ee = (k == 0) ? 7'h7f : 7'h00;
    re = (k == 1) ? 7'h7f : 7'h00;
    xr = (k == 2) ? 7'h7f : 7'h00;
    #1;
    chk({25'h0, ce}, {25'h0, xf});
    chk({25'h0, cc}, {25'h0, xcs});
  endtask
  initial begin
    {pwr, dbl, os, sw} = 4'h8;
    {ee, re, xr} = 21'h0;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    rw(1'b0, OF, 32'h0, 1'b0);
    chk(rd, ECC_CTRL_RESET);
    rw(1'b1, OF, 32'hffff_ffff, 1'b0);
    rw(1'b0, OF, 32'h0, 1'b0);
    chk(rd, 32'h6e6e);
    rw(1'b0, 12'h09c, 32'h0, 1'b0);
    chk(rd, 32'h0);
    sw = 1'b1;
    rw(1'b1, OF, 32'h0, 1'b0);
    rw(1'b0, OF, 32'h0, 1'b0);
    chk(rd, 32'h6e6e);
    // Core off, double lock, OS lock
    for (int i = 0; i < 3; i++) begin
      {pwr, dbl, os, sw} = {i != 0, i == 1, i == 2, 1'b0};
      rw(1'b1, OF, 32'h0, 1'b1);
      rw(1'b0, OF, 32'h0, 1'b1);
      chk(rd, 32'h0);
    end
    {pwr, dbl, os} = 3'h4;
    for (int i = 0; i < 4; i++) begin
      rw(1'b0, OF, 32'h0, 1'b0);
      chk(rd, cv[(i + 3) % 4]);
      rw(1'b1, OF, cv[i], 1'b0);
      ev_chk(0, xe[i], xc[i]);
      ev_chk(1, xe[i], xc[i]);
      ev_chk(2, xx[i], xc[i]);
      ev_chk(3, 7'h00, 7'h00);
    end
    rw(1'b1, OF, 32'h6e6e, 1'b0);
    rw(1'b0, OF, 32'h0, 1'b0);
    chk(rd, 32'h6e6e);
    rst = 1'b1;
    @(posedge clock);
    #1;
    rst = 1'b0;
    rw(1'b0, OF, 32'h0, 1'b0);
    chk(rd, ECC_CTRL_RESET);
    give_verdict();
  end
endmodule // tb_exception_catch_control
